// ### rtl/eab_pkg.sv
// Package with constants and carrier types for the external address bus visibility block.
package eab_pkg;
    localparam int ADDR_W = 24;
    localparam logic [23:0] ADDR_RST = 24'h000000;
    localparam logic STROBE_IDLE = 1'b1;

    // Request from the CPU side: an internal peripheral access, an external cycle, or both at once.
    typedef struct packed {
        logic int_acc;
        logic ext_acc;
        logic wr;
        logic [23:0] addr;
    } eab_req_t;

    // External bus control strobes, all active low except the address latch enable.
    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic cs_n;
        logic ale;
    } eab_ctl_t;

    localparam eab_ctl_t CTL_IDLE = '{rd_n: 1'b1, wr_n: 1'b1, cs_n: 1'b1, ale: 1'b0};

    typedef enum logic [1:0] {
        EAB_IDLE = 2'b00,
        EAB_INT = 2'b01,
        EAB_EXT = 2'b11
    } eab_state_t;
endpackage

// ### rtl/eab_visibility.sv
// External address bus driver with internal peripheral-bus access visibility.
`timescale 1ns/1ps
`default_nettype none
module eab_visibility (
    input wire logic CLOCK, // System clock, 100 MHz.
    input wire logic RST_N, // Asynchronous reset, active low.
    input wire eab_pkg::eab_req_t REQ, // Access request of the current cycle.
    output logic [23:0] A_OUT, // Address pin output value.
    output logic A_OE_N, // Address pin output enable, low while driving.
    output eab_pkg::eab_ctl_t CTL // External control strobes.
);
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    // Decoded request of the current cycle.
    logic int_only;
    logic ext_any;
    logic ext_only;
    logic both_req;
    // Registered history of earlier cycles.
    logic [23:0] addr_r;
    eab_pkg::eab_state_t state_r;
    logic rd_n_r;
    logic wr_n_r;
    logic cs_n_r;
    logic ale_r;
    // Values on their way to the pins.
    wire logic [23:0] pin_addr;
    logic pin_oe_n;
    eab_pkg::eab_ctl_t ctl_pend;
    eab_pkg::eab_ctl_t ctl_pin;

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    // An internal and an external request in one cycle form a refused
    // pair: the external address takes the pins, but no strobe follows,
    // because the internal access still owns the cycle.
    // Decoding once here keeps every later process except the strobe gate, which reads REQ.int_acc directly, on the same view.
    always_comb begin
        int_only = 1'b0;
        ext_any = 1'b0;
        ext_only = 1'b0;
        both_req = 1'b0;
        if (REQ.ext_acc) begin
            ext_any = 1'b1;
            if (REQ.int_acc) begin
                both_req = 1'b1;
            end else begin
                ext_only = 1'b1;
            end
        end else if (REQ.int_acc) begin
            int_only = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Address hold register
    // ------------------------------------------------------------
    // The address of whichever access ran last stays on the pins, so an idle
    // bus still shows internal addresses; attached inputs need hysteresis.
    // Only reset clears it; after that it only changes when a new access arrives.
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            addr_r <= eab_pkg::ADDR_RST;
        end else if (ext_any) begin
            addr_r <= REQ.addr;
        end else if (int_only) begin
            addr_r <= REQ.addr;
        end
    end

    // ------------------------------------------------------------
    // Access state
    // ------------------------------------------------------------
    // The state records what kind of access the previous cycle carried.
    // Only a lone external access leaves a strobe pending for the next cycle,
    // so the strobe path below checks only that state, besides the current internal request.
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            state_r <= eab_pkg::EAB_IDLE;
        end else begin
            case (state_r)
                // From idle any kind of access may start.
                eab_pkg::EAB_IDLE: begin
                    if (ext_only) begin
                        state_r <= eab_pkg::EAB_EXT;
                    end else if (int_only || both_req) begin
                        state_r <= eab_pkg::EAB_INT;
                    end else begin
                        state_r <= eab_pkg::EAB_IDLE;
                    end
                end
                // A refused pair counts as internal, so it leaves no strobe behind.
                eab_pkg::EAB_INT: begin
                    if (ext_only) begin
                        state_r <= eab_pkg::EAB_EXT;
                    end else if (int_only || both_req) begin
                        state_r <= eab_pkg::EAB_INT;
                    end else begin
                        state_r <= eab_pkg::EAB_IDLE;
                    end
                end
                // Back-to-back external accesses keep the strobe phase running.
                eab_pkg::EAB_EXT: begin
                    if (ext_only) begin
                        state_r <= eab_pkg::EAB_EXT;
                    end else if (int_only || both_req) begin
                        state_r <= eab_pkg::EAB_INT;
                    end else begin
                        state_r <= eab_pkg::EAB_IDLE;
                    end
                end
                default: begin
                    state_r <= eab_pkg::EAB_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Strobe registers
    // ------------------------------------------------------------
    // Each strobe has its own register. Direction strobes hold the last lone
    // external access, while select and latch enable follow it for one cycle.
    // Whether any of them reaches the pins is decided by the state and by the internal request of this cycle.
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            rd_n_r <= eab_pkg::CTL_IDLE.rd_n;
        end else if (ext_only) begin
            rd_n_r <= REQ.wr;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            wr_n_r <= eab_pkg::CTL_IDLE.wr_n;
        end else if (ext_only) begin
            wr_n_r <= !REQ.wr;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            cs_n_r <= eab_pkg::CTL_IDLE.cs_n;
        end else begin
            cs_n_r <= !ext_only;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            ale_r <= eab_pkg::CTL_IDLE.ale;
        end else begin
            ale_r <= ext_only;
        end
    end

    // The pending strobe set travels as one struct from here on.
    always_comb begin
        ctl_pend.rd_n = rd_n_r;
        ctl_pend.wr_n = wr_n_r;
        ctl_pend.cs_n = cs_n_r;
        ctl_pend.ale = ale_r;
    end

    // ------------------------------------------------------------
    // Control strobes
    // ------------------------------------------------------------
    // Strobes are forced idle combinationally so an internal access in this
    // cycle can never overlap a registered external strobe. The cost is a
    // short combinational path from the request to the strobe pins.
    always_comb begin
        ctl_pin = eab_pkg::CTL_IDLE;
        if (REQ.int_acc) begin
            ctl_pin = eab_pkg::CTL_IDLE;
        end else if (state_r == eab_pkg::EAB_EXT) begin
            ctl_pin = ctl_pend;
        end
    end
    assign CTL = ctl_pin;

    // ------------------------------------------------------------
    // Address output enable
    // ------------------------------------------------------------
    // Tri-state follows the request in the same cycle rather than a register,
    // which is what keeps it free of a lag cycle. A refused pair keeps the
    // pins driven, since the external address wins them.
    always_comb begin
        pin_oe_n = 1'b0;
        if (int_only) begin
            pin_oe_n = 1'b1;
        end
    end
    assign A_OE_N = pin_oe_n;

    // ------------------------------------------------------------
    // Address pins
    // ------------------------------------------------------------
    // Each pin shows the new address in an external cycle and otherwise the
    // address accessed last, which is why internal addresses leak onto an
    // idle bus after the enable returns.
    for (genvar b = 0; b < eab_pkg::ADDR_W; b++) begin : g_addr_bit
        logic bit_val;
        always_comb begin
            if (ext_any) begin
                bit_val = REQ.addr[b];
            end else begin
                bit_val = addr_r[b];
            end
        end
        assign pin_addr[b] = bit_val;
    end
    assign A_OUT = pin_addr;
endmodule
`default_nettype wire

// ### tb/eab_partner.sv
// External memory model that counts the bus cycles it takes as valid.
`timescale 1ns/1ps
`default_nettype none
module eab_partner (
    input wire logic CLOCK, // Clock.
    input wire eab_pkg::eab_ctl_t CTL, // Strobes.
    output int n_cyc // Valid cycles seen.
);
    initial n_cyc = 0;
    always @(posedge CLOCK) if (!CTL.cs_n) n_cyc <= n_cyc + 1;
endmodule
`default_nettype wire

// ### tb/eab_visibility_bench.sv
// Random bench for the external address bus visibility block.
`timescale 1ns/1ps
`default_nettype none
module eab_visibility_bench;
    logic CLOCK = 0, RST_N = 0, A_OE_N;
    logic [23:0] A_OUT, held = eab_pkg::ADDR_RST;
    logic [31:0] s = 32'h0000005F;
    logic [1:0] op, prev = 2'h0;
    logic prev_wr = 1'b0;
    eab_pkg::eab_req_t REQ = '0;
    eab_pkg::eab_ctl_t CTL;
    int fails = 0, n_tests = 0, n_cyc, n_exp = 0;
    always #5 CLOCK = ~CLOCK;
    eab_visibility uut (.CLOCK, .RST_N, .REQ, .A_OUT, .A_OE_N, .CTL);
    eab_partner mem (.CLOCK, .CTL, .n_cyc);
    function automatic logic [31:0] xorshift(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Op bit 0 asks for an internal access and bit 1 for an external one.
    function automatic logic exp_strobe(input logic [1:0] last, now);
        return last == 2'h2 && !now[0];
    endfunction
    function automatic eab_pkg::eab_ctl_t exp_ctl(input logic [1:0] last, now, input logic w);
        eab_pkg::eab_ctl_t c;
        c = eab_pkg::CTL_IDLE;
        if (exp_strobe(last, now)) c = '{w, !w, 1'b0, 1'b1};
        return c;
    endfunction
    task automatic chk_addr(input string n, input logic [23:0] e, g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s %h %h", n, e, g);
        end
    endtask
    task automatic chk_flag(input string n, input logic e, g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s %h %h", n, e, g);
        end
    endtask
    task automatic chk_ctl(input string n, input eab_pkg::eab_ctl_t e, g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s %h %h", n, e, g);
        end
    endtask
    task automatic chk_count(input string n, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s %0d %0d", n, e, g);
        end
    endtask
    task automatic print_verdict;
        $display("fails %0d n_tests %0d", fails, n_tests);
        if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #20000 fails++;
        print_verdict;
    end
    initial begin
        repeat (5) @(negedge CLOCK);
        RST_N = 1;
        for (int i = 0; i < 400; i++) begin
            s = xorshift(s);
            op = i < 8 ? 2'(32'h02321201 >> 4 * i) : s[3:2];
            REQ = '{op[0], op[1], s[0], i == 2 ? 24'hFFFFFF : s[31:8]};
            n_exp += int'(exp_strobe(prev, op));
            #1 chk_flag("oe", op == 2'h1, A_OE_N);
            chk_ctl("ctl", exp_ctl(prev, op, prev_wr), CTL);
            if (op != 2'h1) chk_addr("addr", op[1] ? REQ.addr : held, A_OUT);
            if (op != 2'h0) held = REQ.addr;
            prev = op;
            prev_wr = REQ.wr;
            @(negedge CLOCK);
        end
        REQ = '0;
        n_exp += int'(exp_strobe(prev, 2'h0));
        repeat (2) @(negedge CLOCK);
        chk_count("strobes", n_exp, n_cyc);
        print_verdict;
    end
endmodule
bind eab_visibility eab_visibility_properties chk (.CLOCK, .RST_N, .REQ, .A_OUT, .A_OE_N, .CTL);
`default_nettype wire

// ### tb/eab_visibility_properties.sv
// Checker for the address enable, address pins and strobes.
`timescale 1ns/1ps
`default_nettype none
module eab_visibility_properties (
    input wire logic CLOCK, // Clock.
    input wire logic RST_N, // Reset.
    input wire eab_pkg::eab_req_t REQ, // Request.
    input wire logic [23:0] A_OUT, // Address.
    input wire logic A_OE_N, // Enable.
    input wire eab_pkg::eab_ctl_t CTL // Strobes.
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    chk_oe_float: assert property (REQ.int_acc && !REQ.ext_acc |-> A_OE_N) else $error("oe");
    chk_oe_no_lag: assert property (!REQ.int_acc |-> !A_OE_N) else $error("lag");
    chk_held_addr: assert property (REQ.int_acc ##1 !REQ.int_acc && !REQ.ext_acc
        |-> A_OUT == $past(REQ.addr)) else $error("held");
    chk_strobe_idle: assert property (REQ.int_acc |-> CTL == eab_pkg::CTL_IDLE) else $error("ctl");
    chk_ext_addr: assert property (REQ.ext_acc |-> A_OUT == REQ.addr) else $error("ext");
    chk_ext_after_int: assert property (REQ.int_acc ##1 REQ.ext_acc
        |-> A_OUT == REQ.addr && !A_OE_N) else $error("ext after int");
    chk_pair_refused: assert property (REQ.int_acc && REQ.ext_acc
        |-> !A_OE_N && CTL == eab_pkg::CTL_IDLE) else $error("pair");
    chk_strobe_issued: assert property (REQ.ext_acc && !REQ.int_acc ##1 !REQ.int_acc
        |-> !CTL.cs_n && CTL.ale) else $error("strobe");
endmodule
`default_nettype wire
